// File: include/ext_bus_pkg.sv
`default_nettype none
package ext_bus_pkg;
    // port indices in the pin arrays
    localparam int NUM_PORTS = 7;
    localparam int NUM_OUT_PORTS = 6;
    localparam int IDX_LOW = 0;
    localparam int IDX_CC = 1;
    localparam int IDX_HIGH = 2;
    localparam int IDX_SER = 3;
    localparam int IDX_GP4 = 4;
    localparam int IDX_GP5 = 5;
    localparam int IDX_ANA = 6;
    // serial/strobe port bit positions
    localparam int BIT_RX = 0;
    localparam int BIT_TX = 1;
    localparam int BIT_IRQ0 = 2;
    localparam int BIT_IRQ1 = 3;
    localparam int BIT_CNT0 = 4;
    localparam int BIT_CNT1 = 5;
    localparam int BIT_WRS = 6;
    localparam int BIT_RDS = 7;
    // capture/compare port bit positions
    localparam int NUM_CC = 4;
    localparam int BIT_IRQ2 = 4;
    localparam int BIT_RELOAD = 5;
    localparam int BIT_SYSTEM_CLOCK_OUTPUT = 6;
    localparam int BIT_CNT2 = 7;
    // machine cycle: six states of two oscillator periods
    localparam logic [2:0] LAST_STATE = 3'h5;
    localparam logic [2:0] HALF_LAST_STATE = 3'h2;
    localparam logic [2:0] HALF_STATE = 3'h3;
    // oscillator position within a six-period half
    localparam logic [2:0] ALE_LAST_POS = 3'h1;
    localparam logic [2:0] ADDR_LAST_POS = 3'h2;
    localparam logic [2:0] STROBE_FIRST_POS = 3'h3;
    localparam logic [2:0] LAST_POS = 3'h5;
    localparam logic [2:0] CAPTURE_POS = 3'h1;
    // reset pin qualification
    localparam int OSC_PER_MC = 12;
    localparam int RESET_MC = 2;
    localparam int RESET_OSC = RESET_MC * OSC_PER_MC;
    localparam logic [4:0] RESET_LAST = 5'(RESET_OSC - 1);
    // internal program memory size
    localparam logic [16:0] INT_ROM_BYTES = 17'h02000;
    // sync control bit positions
    localparam int CTL_SAVE = 0;
    localparam int CTL_EXTSEL = 1;
    localparam logic [7:0] ALL_ON = 8'hFF;
    localparam logic [7:0] ALL_OFF = 8'h00;
    localparam logic [1:0] CTL_RESET = 2'h1;

    // one port's pin drive: value, strong enable, weak pullup
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
    } pin_drive_s;

    // external data memory request from the core
    typedef struct packed {
        logic req;
        logic wr;
        logic ptr16;
        logic [15:0] addr;
        logic [7:0] wdata;
    } xdata_req_s;

    // secondary inputs, idle high when gated off
    typedef struct packed {
        logic serial_rx;
        logic ext_interrupt_zero;
        logic ext_interrupt_one;
        logic ext_interrupt_two;
        logic counter_zero_input;
        logic counter_one_input;
        logic counter_two_input;
        logic timer_two_reload_trigger;
        logic [3:0] capcomp_in;
    } sec_in_s;

    // power state, gray along run-idle-down
    typedef enum logic [1:0] {
        PS_RUN = 2'b00,
        PS_IDLE = 2'b01,
        PS_DOWN = 2'b11
    } power_e;
endpackage
`default_nettype wire

// File: hw/osc_timing.sv
`default_nettype none
module osc_timing (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic freeze,
    input wire logic reset_pin_n,
    output logic clk_phase,
    output logic [2:0] mc_state,
    output logic system_clock_output,
    output logic core_reset
);
    import ext_bus_pkg::*;

    // all timing state
    typedef struct packed {
        logic phase;
        logic [2:0] state;
        logic system_clock_output;
        logic rs1;
        logic rs2;
        logic [4:0] rcnt;
        logic core_reset;
    } timing_s;

    timing_s q, d;

    // divider, state counter, clock output, reset qualifier
    always_comb begin
        d = q;
        d.rs1 = reset_pin_n;
        d.rs2 = q.rs1;
        if (!freeze) begin
            d.phase = ~q.phase;
            if (q.phase) begin
                d.state = (q.state == LAST_STATE) ? 3'h0 : q.state + 3'h1;
                // toggle twice per machine cycle
                if (q.state == LAST_STATE || q.state == HALF_LAST_STATE) begin
                    d.system_clock_output = ~q.system_clock_output;
                end
            end
        end
        // pin must stay low for two machine cycles
        if (q.rs2) begin
            d.rcnt = 5'h00;
            d.core_reset = 1'b0;
        end else if (q.rcnt == RESET_LAST) begin
            d.core_reset = 1'b1;
        end else begin
            d.rcnt = q.rcnt + 5'h01;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{phase: 1'b0, state: 3'h0, system_clock_output: 1'b0, rs1: 1'b1,
                   rs2: 1'b1, rcnt: 5'h00, core_reset: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign clk_phase = q.phase;
    assign mc_state = q.state;
    assign system_clock_output = q.system_clock_output;
    assign core_reset = q.core_reset;
endmodule
`default_nettype wire

// File: hw/ext_bus_pins.sv
`default_nettype none
module ext_bus_pins #(
    parameter logic [16:0] INT_ROM_SIZE = ext_bus_pkg::INT_ROM_BYTES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reset_pin_n,
    input wire logic power_save_enable_n,
    input wire logic external_access_select,
    input wire logic [ext_bus_pkg::NUM_PORTS-1:0][7:0] port_pins,
    input wire logic [ext_bus_pkg::NUM_OUT_PORTS-1:0][7:0] port_latch,
    input wire logic idle_req,
    input wire logic pdown_req,
    input wire logic wake,
    input wire logic [15:0] fetch_addr,
    input wire ext_bus_pkg::xdata_req_s xreq,
    input wire logic serial_tx,
    input wire logic system_clock_output_en,
    input wire logic [ext_bus_pkg::NUM_CC-1:0] compare_en,
    input wire logic [ext_bus_pkg::NUM_CC-1:0] compare_val,
    input wire logic verify_mode,
    input wire logic [7:0] verify_code,
    input wire logic [2:0] adc_channel,
    output logic core_reset,
    output ext_bus_pkg::power_e power_state,
    output logic fetch_ack,
    output logic fetch_internal,
    output logic [7:0] fetch_data,
    output logic xreq_ack,
    output logic [7:0] xrdata,
    output logic xrdata_valid,
    output logic addr_latch_strobe,
    output logic program_fetch_strobe_n,
    output ext_bus_pkg::pin_drive_s low_addr_data_port,
    output ext_bus_pkg::pin_drive_s capcomp_port,
    output ext_bus_pkg::pin_drive_s high_addr_port,
    output ext_bus_pkg::pin_drive_s serial_strobe_port,
    output ext_bus_pkg::pin_drive_s general_port_four,
    output ext_bus_pkg::pin_drive_s general_port_five,
    output logic [ext_bus_pkg::NUM_PORTS-1:0][7:0] port_read,
    output ext_bus_pkg::sec_in_s sec_in,
    output logic [7:0] verify_addr_lo,
    output logic [7:0] analog_mux_sel
);
    import ext_bus_pkg::*;

    // all bus and pin state
    typedef struct packed {
        logic [NUM_PORTS-1:0][7:0] sync1; // pin first stage
        logic [NUM_PORTS-1:0][7:0] sync2; // pin second stage
        logic [1:0] ctl1; // control pins first stage
        logic [1:0] ctl2; // control pins second stage
        logic fetch_half; // this half is a code fetch
        logic bus_ext; // this half uses the external bus
        logic xd; // this machine cycle is a data access
        logic xd_wr; // data access writes
        logic xd_p16; // data access uses a 16-bit pointer
        logic [15:0] addr; // address on the bus
        logic [7:0] wdata; // write data
        logic cap_f; // fetch capture pending
        logic cap_e; // pending fetch was external
        logic cap_r; // read capture pending
        logic [7:0] fdata; // fetched byte
        logic fack; // fetch done pulse
        logic [7:0] rdata; // read byte
        logic rvalid; // read done pulse
        logic xack; // data request taken pulse
        power_e pstate; // power mode
    } bus_s;

    bus_s q, d;
    logic clk_phase; // halved oscillator
    logic [2:0] mc_state; // state within machine cycle
    logic system_clock_output; // oscillator over twelve
    logic freeze; // oscillator stopped
    logic [2:0] pos; // oscillator period within half
    logic second_half; // later half of machine cycle
    logic boundary; // last period of a half
    logic xd_half1; // data strobe half
    logic xstrobe; // data strobe window
    logic rd_n; // data read strobe
    logic wr_n; // data write strobe
    logic addr_phase; // address on low port

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn || core_reset);

    // position of an oscillator period inside a half
    function automatic logic [2:0] half_pos(input logic [2:0] st,
                                            input logic ph);
        logic [2:0] s;
        s = (st >= HALF_STATE) ? st - HALF_STATE : st;
        return {s[1:0], ph};
    endfunction

    // quasi-bidirectional drive from a latch byte
    function automatic pin_drive_s quasi(input logic [7:0] v);
        pin_drive_s p;
        p.o = ALL_OFF;
        p.oe = ~v;
        p.pu = v;
        return p;
    endfunction

    // secondary input passes only with its latch at one
    function automatic logic gate_in(input logic lat, input logic pin);
        return lat ? pin : 1'b1;
    endfunction

    // fetch goes outside unless internal memory covers it
    function automatic logic fetch_ext(input logic sel,
                                       input logic [15:0] a);
        return !(sel && ({1'b0, a} < INT_ROM_SIZE));
    endfunction

    osc_timing u_timing (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .freeze(freeze),
        .reset_pin_n(reset_pin_n),
        .clk_phase(clk_phase),
        .mc_state(mc_state),
        .system_clock_output(system_clock_output),
        .core_reset(core_reset)
    );

    // timing decode
    always_comb begin
        freeze = (q.pstate == PS_DOWN);
        pos = half_pos(mc_state, clk_phase);
        second_half = (mc_state >= HALF_STATE);
        boundary = !freeze && (pos == LAST_POS);
        xd_half1 = q.xd && second_half;
        addr_phase = q.bus_ext && !xd_half1 && (pos <= ADDR_LAST_POS);
        xstrobe = q.xd && (second_half || pos >= STROBE_FIRST_POS);
        rd_n = !(xstrobe && !q.xd_wr);
        wr_n = !(xstrobe && q.xd_wr);
    end

    // next state: syncs, captures, power mode, bus plan
    always_comb begin
        d = q;
        d.sync1 = port_pins;
        d.sync2 = q.sync1;
        d.ctl1 = {external_access_select, power_save_enable_n};
        d.ctl2 = q.ctl1;
        d.fack = 1'b0;
        d.rvalid = 1'b0;
        d.xack = 1'b0;
        // late capture covers the two synchroniser stages
        if (pos == CAPTURE_POS || freeze) begin
            if (q.cap_f) begin
                d.fack = 1'b1;
                if (q.cap_e) begin
                    d.fdata = q.sync2[IDX_LOW];
                end
            end
            if (q.cap_r) begin
                d.rdata = q.sync2[IDX_LOW];
                d.rvalid = 1'b1;
            end
            d.cap_f = 1'b0;
            d.cap_r = 1'b0;
        end
        // power saving entered only between machine cycles; wake leaves idle at once
        if (q.pstate == PS_IDLE && wake) begin
            d.pstate = PS_RUN;
        end else if (q.pstate == PS_RUN && boundary && second_half
                     && !q.ctl2[CTL_SAVE]) begin
            if (pdown_req) begin
                d.pstate = PS_DOWN;
            end else if (idle_req) begin
                d.pstate = PS_IDLE;
            end
        end
        if (boundary) begin
            d.cap_f = q.fetch_half;
            d.cap_e = q.bus_ext;
            d.cap_r = xd_half1 && !q.xd_wr;
            if (d.pstate != PS_RUN) begin
                // nothing planned while saving power
                d.fetch_half = 1'b0;
                d.bus_ext = 1'b0;
                d.xd = 1'b0;
            end else if (second_half && xreq.req) begin
                // data access takes a whole machine cycle
                d.xd = 1'b1;
                d.xack = 1'b1;
                d.xd_wr = xreq.wr;
                d.xd_p16 = xreq.ptr16;
                d.addr = xreq.addr;
                d.wdata = xreq.wdata;
                d.fetch_half = 1'b0;
                d.bus_ext = 1'b1;
            end else if (q.xd && !second_half) begin
                // continue into the strobe half
                d.fetch_half = 1'b0;
                d.bus_ext = 1'b1;
            end else begin
                d.xd = 1'b0;
                d.fetch_half = 1'b1;
                d.bus_ext = fetch_ext(q.ctl2[CTL_EXTSEL], fetch_addr);
                d.addr = fetch_addr;
            end
        end
        if (core_reset) begin
            d.pstate = PS_RUN;
            d.fetch_half = 1'b0;
            d.bus_ext = 1'b0;
            d.xd = 1'b0;
            d.cap_f = 1'b0;
            d.cap_r = 1'b0;
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{sync1: '1, sync2: '1, ctl1: CTL_RESET, ctl2: CTL_RESET,
                   pstate: PS_RUN, default: '0};
        end else begin
            q <= d;
        end
    end

    // bus strobes
    always_comb begin
        addr_latch_strobe = !core_reset && (pos <= ALE_LAST_POS)
                            && (q.fetch_half || (q.xd && !second_half));
        program_fetch_strobe_n = !(q.fetch_half && q.bus_ext
                                   && pos >= STROBE_FIRST_POS);
    end

    // low address/data port
    always_comb begin
        low_addr_data_port.pu = ALL_OFF;
        if (verify_mode) begin
            low_addr_data_port.o = ALL_OFF;
            low_addr_data_port.oe = ~verify_code;
        end else if (addr_phase) begin
            low_addr_data_port.o = q.addr[7:0];
            low_addr_data_port.oe = ALL_ON;
        end else if (!wr_n) begin
            low_addr_data_port.o = q.wdata;
            low_addr_data_port.oe = ALL_ON;
        end else if (q.bus_ext) begin
            // released for code or read data
            low_addr_data_port.o = ALL_OFF;
            low_addr_data_port.oe = ALL_OFF;
        end else begin
            low_addr_data_port.o = ALL_OFF;
            low_addr_data_port.oe = ~port_latch[IDX_LOW];
        end
    end

    // high address port
    always_comb begin
        if (q.bus_ext && (q.fetch_half || q.xd_p16)) begin
            high_addr_port.o = q.addr[15:8];
            high_addr_port.oe = ALL_ON;
            high_addr_port.pu = ALL_OFF;
        end else begin
            high_addr_port = quasi(port_latch[IDX_HIGH]);
        end
    end

    // serial and strobe port
    always_comb begin
        logic [7:0] v;
        v = port_latch[IDX_SER];
        v[BIT_TX] = v[BIT_TX] & serial_tx;
        v[BIT_WRS] = v[BIT_WRS] & wr_n;
        v[BIT_RDS] = v[BIT_RDS] & rd_n;
        serial_strobe_port = quasi(v);
    end

    // capture/compare port
    always_comb begin
        logic [7:0] v;
        v = verify_mode ? ALL_ON : port_latch[IDX_CC];
        if (system_clock_output_en) begin
            v[BIT_SYSTEM_CLOCK_OUTPUT] = v[BIT_SYSTEM_CLOCK_OUTPUT] & system_clock_output;
        end
        capcomp_port = quasi(v);
        for (int i = 0; i < NUM_CC; i++) begin
            if (compare_en[i] && !verify_mode) begin
                capcomp_port.o[i] = compare_val[i];
                capcomp_port.oe[i] = 1'b1;
                capcomp_port.pu[i] = 1'b0;
            end
        end
    end

    // plain quasi ports
    always_comb begin
        general_port_four = quasi(port_latch[IDX_GP4]);
        general_port_five = quasi(port_latch[IDX_GP5]);
    end

    // secondary inputs and reads
    always_comb begin
        logic [7:0] s;
        logic [7:0] c;
        logic [7:0] l3;
        logic [7:0] l1;
        s = q.sync2[IDX_SER];
        c = q.sync2[IDX_CC];
        l3 = port_latch[IDX_SER];
        l1 = port_latch[IDX_CC];
        sec_in.serial_rx = gate_in(l3[BIT_RX], s[BIT_RX]);
        sec_in.ext_interrupt_zero = gate_in(l3[BIT_IRQ0], s[BIT_IRQ0]);
        sec_in.ext_interrupt_one = gate_in(l3[BIT_IRQ1], s[BIT_IRQ1]);
        sec_in.counter_zero_input = gate_in(l3[BIT_CNT0], s[BIT_CNT0]);
        sec_in.counter_one_input = gate_in(l3[BIT_CNT1], s[BIT_CNT1]);
        sec_in.ext_interrupt_two = gate_in(l1[BIT_IRQ2], c[BIT_IRQ2]);
        sec_in.timer_two_reload_trigger = gate_in(l1[BIT_RELOAD],
                                                  c[BIT_RELOAD]);
        sec_in.counter_two_input = gate_in(l1[BIT_CNT2], c[BIT_CNT2]);
        for (int i = 0; i < NUM_CC; i++) begin
            sec_in.capcomp_in[i] = gate_in(l1[i], c[i]);
        end
        port_read = q.sync2;
        verify_addr_lo = c;
        analog_mux_sel = ALL_OFF;
        analog_mux_sel[adc_channel] = 1'b1;
    end

    // registered core-side outputs
    assign power_state = q.pstate;
    assign fetch_ack = q.fack;
    assign fetch_data = q.fdata;
    assign fetch_internal = q.fetch_half && !q.bus_ext;
    assign xreq_ack = q.xack;
    assign xrdata = q.rdata;
    assign xrdata_valid = q.rvalid;

    // strobe sequences
    sequence s_next_half_strobe;
        ##6 (addr_latch_strobe || xd_half1 || !(q.fetch_half || q.xd));
    endsequence
    sequence s_read_window;
        ##1 !rd_n [*8] ##1 rd_n;
    endsequence

    property p_ale_period;
        $rose(addr_latch_strobe) |-> s_next_half_strobe;
    endproperty
    a_ale_period: assert property (p_ale_period)
        else $error("latch strobe missed its six-period slot");

    property p_ale_skip;
        xd_half1 |-> !addr_latch_strobe;
    endproperty
    a_ale_skip: assert property (p_ale_skip)
        else $error("latch strobe during data strobe half");

    property p_program_fetch_strobe_data;
        q.xd |-> program_fetch_strobe_n;
    endproperty
    a_program_fetch_strobe_data: assert property (p_program_fetch_strobe_data)
        else $error("fetch strobe during data access");

    property p_program_fetch_strobe_internal;
        fetch_internal |-> program_fetch_strobe_n
                           && ($stable(q.addr) || $past(boundary));
    endproperty
    a_program_fetch_strobe_internal: assert property (p_program_fetch_strobe_internal)
        else $error("fetch strobe during internal execution");

    property p_read_width;
        $fell(rd_n) |-> s_read_window;
    endproperty
    a_read_width: assert property (p_read_width)
        else $error("read strobe not nine periods wide");

    property p_high_hold;
        q.xd && !q.xd_p16 |-> high_addr_port.oe == ~port_latch[IDX_HIGH]
                              && high_addr_port.pu == port_latch[IDX_HIGH];
    endproperty
    a_high_hold: assert property (p_high_hold)
        else $error("high port left its latch in short access");

    property p_write_data;
        !wr_n && !verify_mode |-> low_addr_data_port.o == q.wdata
                                  && low_addr_data_port.oe == ALL_ON;
    endproperty
    a_write_data: assert property (p_write_data)
        else $error("write data not driven under write strobe");

    property p_open_drain;
        !q.bus_ext && !verify_mode |-> low_addr_data_port.pu == ALL_OFF
            && low_addr_data_port.oe == ~port_latch[IDX_LOW];
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("low port not open-drain as general port");

    property p_save_block;
        q.pstate == PS_RUN && q.ctl2[CTL_SAVE] |=> q.pstate == PS_RUN;
    endproperty
    a_save_block: assert property (p_save_block)
        else $error("power saving entered while blocked");

    property p_halve;
        !freeze |=> clk_phase != $past(clk_phase);
    endproperty
    a_halve: assert property (p_halve)
        else $error("divider failed to toggle");
endmodule
`default_nettype wire

// File: bench/ext_mem_model.sv
`default_nettype none
// external memory behind an address latch
module ext_mem_model (
    input wire logic sys_clk,
    input wire logic ale,
    input wire logic fetch_n,
    input wire logic rd_n,
    input wire logic [7:0] bus,
    output logic [7:0] q,
    output logic en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] a = 8'h00; // latched low address
    // loads on each clock edge while strobe high, holds after it falls
    always @(posedge sys_clk) if (ale) a <= bus;
    // byte returned depends on the latched address only
    assign q = a ^ 8'h5A;
    // memory drives the bus while either strobe is low
    assign en = !fetch_n || !rd_n;
endmodule
`default_nettype wire

// File: bench/ext_bus_pins_tb.sv
`default_nettype none
module ext_bus_pins_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ext_bus_pkg::*;
    logic sys_clk, rstn, reset_pin_n, power_save_enable_n;
    logic external_access_select, idle_req, pdown_req, wake;
    logic [6:0][7:0] port_pins, ext;
    logic [5:0][7:0] port_latch;
    logic [15:0] fetch_addr;
    xdata_req_s xreq;
    logic serial_tx, system_clock_output_en, verify_mode, core_reset, en;
    logic [3:0] compare_en, compare_val;
    logic [7:0] verify_code, fetch_data, xrdata, q;
    logic [7:0] verify_addr_lo, analog_mux_sel;
    logic [2:0] adc_channel;
    logic fetch_ack, fetch_internal, xreq_ack, xrdata_valid;
    logic addr_latch_strobe, program_fetch_strobe_n;
    power_e power_state;
    pin_drive_s low_addr_data_port, capcomp_port, high_addr_port;
    pin_drive_s serial_strobe_port, general_port_four, general_port_five;
    pin_drive_s drv [6];
    logic [6:0][7:0] port_read;
    sec_in_s sec_in;
    int mismatches = 0;
    int num_checks = 0;
    int f, r;
    ext_bus_pins ext_bus_pins_inst (.sys_clk, .rstn, .reset_pin_n,
        .power_save_enable_n, .external_access_select, .port_pins,
        .port_latch, .idle_req, .pdown_req, .wake, .fetch_addr, .xreq,
        .serial_tx, .system_clock_output_en, .compare_en, .compare_val, .verify_mode,
        .verify_code, .adc_channel, .core_reset, .power_state, .fetch_ack,
        .fetch_internal, .fetch_data, .xreq_ack, .xrdata, .xrdata_valid,
        .addr_latch_strobe, .program_fetch_strobe_n, .low_addr_data_port,
        .capcomp_port, .high_addr_port, .serial_strobe_port,
        .general_port_four, .general_port_five, .port_read, .sec_in,
        .verify_addr_lo, .analog_mux_sel);
    ext_mem_model ext_mem_model_inst (.sys_clk, .ale(addr_latch_strobe),
        .fetch_n(program_fetch_strobe_n), .rd_n(port_pins[3][7]),
        .bus(port_pins[0]), .q, .en);
    assign drv = '{low_addr_data_port, capcomp_port, high_addr_port,
        serial_strobe_port, general_port_four, general_port_five};
    always #10 sys_clk = ~sys_clk;
    // pin level: strong drive, else far side beats pullup; freed bus flips
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            port_pins[k] = (drv[k].oe & drv[k].o) | (~drv[k].oe &
                (k == 0 ? (en ? q : ~q) : ext[k]));
        end
        port_pins[6] = ext[6];
    end
    // byte the model returns for an address
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ 8'h5A;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [15:0] e, g);
        num_checks++;
        if (e !== g) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    // count strobe edges over eight halves
    task automatic cnt(output int nf, output int nr);
        logic p, l;
        nf = 0;
        nr = 0;
        p = program_fetch_strobe_n;
        l = addr_latch_strobe;
        repeat (48) begin
            tick(1);
            nf += int'(p && !program_fetch_strobe_n);
            nr += int'(!l && addr_latch_strobe);
            p = program_fetch_strobe_n;
            l = addr_latch_strobe;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // watchdog well past the expected run
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end
    initial begin
        sys_clk = 0; rstn = 0; reset_pin_n = 1; power_save_enable_n = 1;
        external_access_select = 0; ext = '1; port_latch = '1;
        idle_req = 0; pdown_req = 0; wake = 0; fetch_addr = 16'h0000;
        xreq = '0; serial_tx = 1; system_clock_output_en = 0; compare_en = 4'h0;
        compare_val = 4'h0; verify_mode = 0; verify_code = 8'h00;
        adc_channel = 3'h0;
        void'($urandom(32'h9BDE));
        tick(5);
        rstn = 1;
        tick(10);
        // external, internal at the top, external at the boundary
        for (int m = 0; m < 3; m++) begin
            external_access_select = (m != 0);
            fetch_addr = m == 1 ? 16'h1FFF : m == 2 ? 16'h2000 : 16'($urandom);
            tick(24);
            cnt(f, r);
            chk("fetch_strobe", m == 1 ? 16'h0 : 16'h8, 16'(f));
            chk("latch_strobe", 16'h8, 16'(r));
            chk("fetch_internal", 16'(m == 1), 16'(fetch_internal));
            if (m != 1) begin
                for (int i = 0; i < 40 && fetch_ack !== 1; i++) tick(1);
                chk("fetch_data", mem_byte(fetch_addr), fetch_data);
            end
            $display("test fetch %0d done", m);
        end
        // read with long pointer, read with short pointer, write
        for (int d = 0; d < 3; d++) begin
            xreq = '{1'b1, d == 2, d != 1, 16'($urandom), 8'($urandom)};
            port_latch[2] = 8'($urandom);
            for (int i = 0; i < 40 && xreq_ack !== 1; i++) tick(1);
            tick(1);
            xreq.req = 0;
            for (int i = 0; i < 40 && port_pins[3][d == 2 ? 6 : 7]; i++)
                tick(1);
            chk("high_port", d == 1 ? port_latch[2] : xreq.addr[15:8],
                port_pins[2]);
            if (d == 2) chk("write_data", xreq.wdata,
                low_addr_data_port.o & low_addr_data_port.oe);
            if (d != 2) begin
                for (int i = 0; i < 40 && xrdata_valid !== 1; i++) tick(1);
                chk("read_data", mem_byte(xreq.addr), xrdata);
            end
            tick(12);
            $display("test data %0d done", d);
        end
        // power saving refused while enable high, then idle and wake
        idle_req = 1;
        tick(30);
        chk("power_blocked", PS_RUN, power_state);
        power_save_enable_n = 0;
        tick(30);
        chk("power_idle", PS_IDLE, power_state);
        idle_req = 0;
        wake = 1;
        tick(30);
        chk("power_wake", PS_RUN, power_state);
        wake = 0;
        $display("test power done");
        // pin functions with random latches
        port_latch = {6{8'($urandom)}} ^ 48'($urandom);
        ext = 56'({$urandom, $urandom});
        serial_tx = 1'($urandom);
        compare_en = 4'hF;
        compare_val = 4'($urandom);
        adc_channel = 3'($urandom);
        tick(4);
        chk("quasi_pullup", port_latch[4],
            general_port_four.pu & port_latch[4]);
        chk("open_drain", 8'h00, low_addr_data_port.pu);
        chk("compare_oe", 4'hF, capcomp_port.oe[3:0]);
        chk("compare_val", compare_val, capcomp_port.o[3:0]);
        chk("tx_pin", port_latch[3][1] & serial_tx & ext[3][1],
            port_pins[3][1]);
        chk("analog_sel", 8'h01 << adc_channel, analog_mux_sel);
        chk("analog_read", ext[6], port_read[6]);
        chk("port_five", port_latch[5] & ext[5], port_read[5]);
        chk("irq0_in", !port_latch[3][2] | ext[3][2],
            sec_in.ext_interrupt_zero);
        chk("capture_in", 4'(~port_latch[1][3:0] | compare_val),
            sec_in.capcomp_in);
        chk("verify_addr", {port_latch[1][7:4] & ext[1][7:4], compare_val},
            verify_addr_lo);
        verify_code = 8'($urandom);
        verify_mode = 1;
        tick(1);
        chk("verify_oe", 8'(~verify_code), low_addr_data_port.oe);
        verify_mode = 0;
        $display("test pins done");
        // power-down, left only through reset
        pdown_req = 1;
        tick(30);
        chk("power_down", PS_DOWN, power_state);
        pdown_req = 0;
        // short reset pulse ignored, two machine cycles taken
        reset_pin_n = 0;
        tick(10);
        reset_pin_n = 1;
        tick(5);
        chk("short_reset", 16'h0, 16'(core_reset));
        reset_pin_n = 0;
        tick(30);
        chk("reset", 16'h1, 16'(core_reset));
        chk("power_reset", PS_RUN, power_state);
        reset_pin_n = 1;
        tick(8);
        chk("reset_end", 16'h0, 16'(core_reset));
        $display("test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
